/* ddr_ctrl_consts.svh */
// constants of the ddr command timing controller
`ifndef DDR_CTRL_CONSTS_SVH
`define DDR_CTRL_CONSTS_SVH

// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define CORE_CLK_NS 10
`define CK_DIV 4
`define TCK_NS (`CORE_CLK_NS * `CK_DIV)
`define NS_TO_TCK(ns) (((ns) + `TCK_NS - 1) / `TCK_NS)
`define SLOW_CK_MHZ 33

// ----------------------------------------------------------------
// widths and sizes
// ----------------------------------------------------------------
`define DQ_W 16
`define ADDR_W 14
`define BANKS 4
`define BURST_LEN 4
`define FIFO_DEPTH 8
`define CAS_LAT 3
`define DENSITY_MB 1024
`define ROWS 8192

// ----------------------------------------------------------------
// timing figures in ns, ms or tCK
// ----------------------------------------------------------------
`define RRD_NS 10
`define RC_NS 55
`define RAS_NS 40
`define RCD_NS 15
`define RP_NS 15
`define WR_NS 12
`define RFC_NS ((`DENSITY_MB <= 256) ? 80 : (`DENSITY_MB == 512) ? 110 : 140)
`define XSR_NS 120
`define REF_WINDOW_MS 64
`define CCD_TCK 1
`define CDLR_TCK 2
`define MRD_TCK 2
`define PDEX_TCK 2
`define CKE_TCK 2
`define DAL_SLOW_TCK 2
`define REF_BURST_MAX 8
`define WDATA_END_TCK 3

// ----------------------------------------------------------------
// derived counts
// ----------------------------------------------------------------
`define REFI_TCK ((`REF_WINDOW_MS * 1000000 / `ROWS) / `TCK_NS)
`define DAL_TCK ((1000 / `TCK_NS < `SLOW_CK_MHZ) ? `DAL_SLOW_TCK : \
  (`NS_TO_TCK(`WR_NS) + `NS_TO_TCK(`RP_NS)))
`define RD_WIN ((`CAS_LAT + `BURST_LEN / 2 + 1) * `CK_DIV + 4)

// ----------------------------------------------------------------
// write strobe schedule, core cycles after the write slot
// ----------------------------------------------------------------
`define WS_DQS_ON 4'h3
`define WS_DQ_ON 4'h6
`define WS_LAST 4'he
`define WS_HI0 4'h7
`define WS_HI1 4'hb

// ----------------------------------------------------------------
// command pins cs_n, ras_n, cas_n, we_n
// ----------------------------------------------------------------
`define PIN_NOP 4'h7
`define PIN_ACT 4'h3
`define PIN_READ 4'h5
`define PIN_WRITE 4'h4
`define PIN_PRE 4'h2
`define PIN_REF 4'h1
`define PIN_MRS 4'h0
`define AP_BIT 10

// ----------------------------------------------------------------
// timer slots
// ----------------------------------------------------------------
`define T_RRD 0
`define T_CCD 1
`define T_WTR 2
`define T_WR 3
`define T_DAL 4
`define T_GAP 5
`define T_CKE 6
`define T_BANK0 7
`define K_RC 0
`define K_RAS 1
`define K_RCD 2
`define K_RP 3
`define NUM_TIMERS 23

`endif

/* ddr_ctrl_pkg.sv */
// types shared by the ddr command timing controller
`include "ddr_ctrl_consts.svh"
package ddr_ctrl_pkg;
  typedef logic [7:0] cnt_t;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ACTIVATE = 4'h1,
    OP_READ = 4'h2,
    OP_WRITE = 4'h3,
    OP_PRECHARGE = 4'h4,
    OP_MODE_LOAD = 4'h5,
    OP_PD_ENTER = 4'h6,
    OP_PD_EXIT = 4'h7,
    OP_SR_ENTER = 4'h8,
    OP_SR_EXIT = 4'h9
  } cmd_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_SELF = 2'b10
  } pwr_e;

  typedef struct packed {
    logic [1:0] ph;
    logic ck;
    logic ck_n;
    logic cke;
    logic [3:0] pins;
    logic [1:0] ba;
    logic [`ADDR_W-1:0] a;
    logic [`DQ_W-1:0] dq;
    logic dq_oe_n;
    logic dqs;
    logic dqs_oe_n;
    logic [3:0] wcnt;
    logic [5:0] rcnt;
    pwr_e pwr;
    logic [`BANKS-1:0] open;
    logic [3:0] owed;
    cnt_t refi;
    logic [2:0] dqs_s;
    logic dqs_acc;
    logic [`DQ_W-1:0] dq_s1;
    logic [`DQ_W-1:0] dq_s2;
    logic [`DQ_W-1:0] dq_s3;
    logic [`DQ_W-1:0] rd_data;
    logic rd_valid;
  } ctrl_s;

  typedef struct packed {
    cnt_t cnt;
  } timer_s;

  function automatic int tix(input int kind, input logic [1:0] bank);
    tix = `T_BANK0 + kind * `BANKS + int'(bank);
  endfunction
endpackage

/* gap_timer.sv */
// down counter that holds off a command for a number of memory clocks
`timescale 1ns/1ps
`default_nettype none
module gap_timer
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic load,
  input wire ddr_ctrl_pkg::cnt_t value,
  output logic done
);
  import ddr_ctrl_pkg::*;

  timer_s st_ff;
  timer_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (load)
      nxt_st.cnt = value;
    else if (tick && (st_ff.cnt != 8'h00))
      nxt_st.cnt = st_ff.cnt - 8'h01;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else if (ce)
      st_ff <= nxt_st;
  end

  assign done = (st_ff.cnt == 8'h00);
endmodule
`default_nettype wire

/* sync_fifo.sv */
// write data buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  import ddr_ctrl_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [LW-1:0] cnt;
  } fifo_s;

  fifo_s st_ff;
  fifo_s nxt_st;
  logic push;
  logic pop;

  assign in_ready = ce && (st_ff.cnt != LW'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = st_ff.mem[st_ff.rp];
  assign level = st_ff.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = st_ff.wp + AW'(1);
    end
    if (pop)
      nxt_st.rp = st_ff.rp + AW'(1);
    nxt_st.cnt = st_ff.cnt + LW'(push) - LW'(pop);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else if (ce)
      st_ff <= nxt_st;
  end
endmodule
`default_nettype wire

/* ddr_timing_ctrl.sv */
// command timing controller that drives a low-power ddr sdram
`timescale 1ns/1ps
`default_nettype none
`include "ddr_ctrl_consts.svh"

module ddr_timing_ctrl
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ddr_ctrl_pkg::cmd_e cmd_op,
  input wire logic [1:0] cmd_bank,
  input wire logic [`ADDR_W-1:0] cmd_addr,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [`DQ_W-1:0] wr_data,
  output logic rd_valid,
  output logic [`DQ_W-1:0] rd_data,
  output logic mem_ck,
  output logic mem_ck_n,
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [1:0] mem_ba,
  output logic [`ADDR_W-1:0] mem_a,
  output logic [1:0] mem_dm,
  output logic [`DQ_W-1:0] mem_dq_o,
  output logic mem_dq_oe_n,
  input wire logic [`DQ_W-1:0] mem_dq_i,
  output logic [1:0] mem_dqs_o,
  output logic [1:0] mem_dqs_oe_n,
  input wire logic [1:0] mem_dqs_i
);
  import ddr_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam ctrl_s RST_ST = '{
    ph: 2'h3,
    ck_n: 1'b1,
    pins: `PIN_NOP,
    dq_oe_n: 1'b1,
    dqs_oe_n: 1'b1,
    pwr: PWR_DOWN,
    refi: cnt_t'(`REFI_TCK - 1),
    default: '0
  };

  ctrl_s st_ff;
  ctrl_s nxt_st;
  logic [`NUM_TIMERS-1:0] done;
  logic [`NUM_TIMERS-1:0] ld;
  cnt_t [`NUM_TIMERS-1:0] val;
  logic slot_c;
  logic busy_c;
  logic due_c;
  logic ok_c;
  logic rdy_c;
  logic pop_c;
  logic all_ras_c;
  logic all_rp_c;
  logic edge_c;
  logic [3:0] m_c;
  logic fifo_valid;
  logic [`DQ_W-1:0] fifo_data;
  logic [3:0] fifo_level;

  // ----------------------------------------------------------------
  // write data buffer
  // ----------------------------------------------------------------
  sync_fifo #(
    .WIDTH(`DQ_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_wfifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(pop_c),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  // ----------------------------------------------------------------
  // interval timers, ticking once per memory clock
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < `NUM_TIMERS; gi++)
  begin : g_tmr
    gap_timer u_tmr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .tick(slot_c),
      .load(ld[gi]),
      .value(val[gi]),
      .done(done[gi])
    );
  end

  // ----------------------------------------------------------------
  // command eligibility, refresh, strobe schedule and read capture
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    ld = '0;
    val = '0;
    pop_c = 1'b0;
    ok_c = 1'b0;
    slot_c = (st_ff.ph == 2'h1);
    busy_c = (st_ff.wcnt != 4'h0) || (st_ff.rcnt != 6'h00);
    due_c = (st_ff.owed != 4'h0) && (st_ff.pwr == PWR_ACTIVE);
    all_ras_c = 1'b1;
    all_rp_c = 1'b1;
    for (int b = 0; b < `BANKS; b++)
    begin
      all_ras_c = all_ras_c && done[tix(`K_RAS, 2'(b))];
      all_rp_c = all_rp_c && done[tix(`K_RP, 2'(b))];
    end

    case (cmd_op)
      OP_NOP:
        ok_c = 1'b1;
      OP_ACTIVATE:
        ok_c = (st_ff.pwr == PWR_ACTIVE) && done[`T_GAP] &&
          !st_ff.open[cmd_bank] && done[`T_RRD] && done[`T_DAL] &&
          done[tix(`K_RC, cmd_bank)] && done[tix(`K_RP, cmd_bank)];
      OP_READ:
        ok_c = (st_ff.pwr == PWR_ACTIVE) && done[`T_GAP] && !busy_c &&
          st_ff.open[cmd_bank] && done[tix(`K_RCD, cmd_bank)] &&
          done[`T_CCD] && done[`T_WTR];
      OP_WRITE:
        ok_c = (st_ff.pwr == PWR_ACTIVE) && done[`T_GAP] && !busy_c &&
          st_ff.open[cmd_bank] && done[tix(`K_RCD, cmd_bank)] &&
          done[`T_CCD] && (fifo_level >= 4'(`BURST_LEN));
      OP_PRECHARGE:
        ok_c = (st_ff.pwr == PWR_ACTIVE) && done[`T_GAP] && !busy_c &&
          done[`T_WR] && (cmd_addr[`AP_BIT] ? all_ras_c :
          done[tix(`K_RAS, cmd_bank)]);
      OP_MODE_LOAD:
        ok_c = (st_ff.pwr == PWR_ACTIVE) && done[`T_GAP] &&
          (st_ff.open == '0) && !busy_c;
      OP_PD_ENTER:
        ok_c = (st_ff.pwr == PWR_ACTIVE) && done[`T_GAP] &&
          done[`T_CKE] && !busy_c;
      OP_PD_EXIT:
        ok_c = (st_ff.pwr == PWR_DOWN) && done[`T_CKE];
      OP_SR_ENTER:
        ok_c = (st_ff.pwr == PWR_ACTIVE) && done[`T_GAP] &&
          done[`T_CKE] && (st_ff.open == '0) && !busy_c;
      OP_SR_EXIT:
        ok_c = (st_ff.pwr == PWR_SELF) && done[`T_CKE];
      default:
        ok_c = 1'b0;
    endcase
    rdy_c = ce && slot_c && !due_c && ok_c;

    // memory clock is core clock over a fixed four, two phases high
    nxt_st.ph = st_ff.ph + 2'h1;
    nxt_st.ck = ~nxt_st.ph[1];
    nxt_st.ck_n = nxt_st.ph[1];

    if (slot_c)
    begin
      nxt_st.pins = `PIN_NOP;
      if (st_ff.refi == 8'h00)
      begin
        nxt_st.refi = cnt_t'(`REFI_TCK - 1);
        if ((st_ff.pwr != PWR_SELF) && (st_ff.owed != 4'(`REF_BURST_MAX)))
          nxt_st.owed = st_ff.owed + 4'h1;
      end
      else
        nxt_st.refi = st_ff.refi - 8'h01;

      if (rdy_c && cmd_valid)
      begin
        nxt_st.ba = cmd_bank;
        nxt_st.a = cmd_addr;
        case (cmd_op)
          OP_ACTIVATE:
          begin
            nxt_st.pins = `PIN_ACT;
            nxt_st.open[cmd_bank] = 1'b1;
            ld[`T_RRD] = 1'b1;
            val[`T_RRD] = cnt_t'(`NS_TO_TCK(`RRD_NS) - 1);
            ld[tix(`K_RC, cmd_bank)] = 1'b1;
            val[tix(`K_RC, cmd_bank)] = cnt_t'(`NS_TO_TCK(`RC_NS) - 1);
            ld[tix(`K_RAS, cmd_bank)] = 1'b1;
            val[tix(`K_RAS, cmd_bank)] = cnt_t'(`NS_TO_TCK(`RAS_NS) - 1);
            ld[tix(`K_RCD, cmd_bank)] = 1'b1;
            val[tix(`K_RCD, cmd_bank)] = cnt_t'(`NS_TO_TCK(`RCD_NS) - 1);
          end
          OP_READ:
          begin
            nxt_st.pins = `PIN_READ;
            ld[`T_CCD] = 1'b1;
            val[`T_CCD] = cnt_t'(`CCD_TCK - 1);
            nxt_st.rcnt = 6'(`RD_WIN);
          end
          OP_WRITE:
          begin
            nxt_st.pins = `PIN_WRITE;
            nxt_st.wcnt = 4'h1;
            ld[`T_CCD] = 1'b1;
            val[`T_CCD] = cnt_t'(`CCD_TCK - 1);
            ld[`T_WTR] = 1'b1;
            val[`T_WTR] = cnt_t'(`WDATA_END_TCK + `CDLR_TCK - 1);
            ld[`T_WR] = 1'b1;
            val[`T_WR] = cnt_t'(`WDATA_END_TCK + `NS_TO_TCK(`WR_NS) - 1);
            ld[`T_DAL] = 1'b1;
            val[`T_DAL] = cnt_t'(`WDATA_END_TCK + `DAL_TCK - 1);
          end
          OP_PRECHARGE:
          begin
            nxt_st.pins = `PIN_PRE;
            for (int b = 0; b < `BANKS; b++)
            begin
              if (cmd_addr[`AP_BIT] || (cmd_bank == 2'(b)))
              begin
                nxt_st.open[b] = 1'b0;
                ld[tix(`K_RP, 2'(b))] = 1'b1;
                val[tix(`K_RP, 2'(b))] = cnt_t'(`NS_TO_TCK(`RP_NS) - 1);
              end
            end
          end
          OP_MODE_LOAD:
          begin
            nxt_st.pins = `PIN_MRS;
            ld[`T_GAP] = 1'b1;
            val[`T_GAP] = cnt_t'(`MRD_TCK - 1);
          end
          OP_PD_ENTER:
          begin
            nxt_st.cke = 1'b0;
            nxt_st.pwr = PWR_DOWN;
            ld[`T_CKE] = 1'b1;
            val[`T_CKE] = cnt_t'(`CKE_TCK - 1);
          end
          OP_PD_EXIT:
          begin
            nxt_st.cke = 1'b1;
            nxt_st.pwr = PWR_ACTIVE;
            ld[`T_CKE] = 1'b1;
            val[`T_CKE] = cnt_t'(`CKE_TCK - 1);
            ld[`T_GAP] = 1'b1;
            val[`T_GAP] = cnt_t'(`PDEX_TCK - 1);
          end
          OP_SR_ENTER:
          begin
            nxt_st.pins = `PIN_REF;
            nxt_st.cke = 1'b0;
            nxt_st.pwr = PWR_SELF;
            ld[`T_CKE] = 1'b1;
            val[`T_CKE] = cnt_t'(`CKE_TCK - 1);
          end
          OP_SR_EXIT:
          begin
            nxt_st.cke = 1'b1;
            nxt_st.pwr = PWR_ACTIVE;
            nxt_st.owed = 4'h0;
            nxt_st.refi = cnt_t'(`REFI_TCK - 1);
            ld[`T_CKE] = 1'b1;
            val[`T_CKE] = cnt_t'(`CKE_TCK - 1);
            ld[`T_GAP] = 1'b1;
            val[`T_GAP] = cnt_t'(`NS_TO_TCK(`XSR_NS) - 1);
          end
          default:
            nxt_st.pins = `PIN_NOP;
        endcase
      end
      else if (due_c && !busy_c && done[`T_GAP] && all_ras_c && done[`T_WR])
      begin
        if (st_ff.open != '0)
        begin
          nxt_st.pins = `PIN_PRE;
          nxt_st.a = '0;
          nxt_st.a[`AP_BIT] = 1'b1;
          nxt_st.open = '0;
          for (int b = 0; b < `BANKS; b++)
          begin
            ld[tix(`K_RP, 2'(b))] = 1'b1;
            val[tix(`K_RP, 2'(b))] = cnt_t'(`NS_TO_TCK(`RP_NS) - 1);
          end
        end
        else if (all_rp_c)
        begin
          nxt_st.pins = `PIN_REF;
          nxt_st.owed = nxt_st.owed - 4'h1;
          ld[`T_GAP] = 1'b1;
          val[`T_GAP] = cnt_t'(`NS_TO_TCK(`RFC_NS) - 1);
        end
      end
    end

    // write strobe and data, m_c is the core cycle being prepared
    m_c = st_ff.wcnt + 4'h1;
    if (st_ff.wcnt != 4'h0)
    begin
      nxt_st.wcnt = m_c;
      nxt_st.dqs_oe_n = !((m_c >= `WS_DQS_ON) && (m_c <= `WS_LAST));
      nxt_st.dqs = (m_c == `WS_HI0) || (m_c == `WS_HI0 + 4'h1) ||
        (m_c == `WS_HI1) || (m_c == `WS_HI1 + 4'h1);
      nxt_st.dq_oe_n = !((m_c >= `WS_DQ_ON) && (m_c <= `WS_LAST));
      if ((m_c >= `WS_DQ_ON) && (m_c < `WS_LAST) && !m_c[0] && fifo_valid)
      begin
        nxt_st.dq = fifo_data;
        pop_c = 1'b1;
      end
    end

    // read window and strobe capture through three stages
    if (st_ff.rcnt != 6'h00)
      nxt_st.rcnt = st_ff.rcnt - 6'h01;
    nxt_st.dqs_s = {st_ff.dqs_s[1:0], mem_dqs_i[0]};
    nxt_st.dq_s1 = mem_dq_i;
    nxt_st.dq_s2 = st_ff.dq_s1;
    nxt_st.dq_s3 = st_ff.dq_s2;
    edge_c = (st_ff.dqs_s[1] == st_ff.dqs_s[2]) &&
      (st_ff.dqs_s[2] != st_ff.dqs_acc);
    nxt_st.rd_valid = 1'b0;
    if (edge_c)
    begin
      nxt_st.dqs_acc = st_ff.dqs_s[2];
      if (st_ff.rcnt != 6'h00)
      begin
        nxt_st.rd_data = st_ff.dq_s3;
        nxt_st.rd_valid = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= RST_ST;
    else if (ce)
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_ready = rdy_c;
  assign rd_valid = st_ff.rd_valid;
  assign rd_data = st_ff.rd_data;
  assign mem_ck = st_ff.ck;
  assign mem_ck_n = st_ff.ck_n;
  assign mem_cke = st_ff.cke;
  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = st_ff.pins;
  assign mem_ba = st_ff.ba;
  assign mem_a = st_ff.a;
  assign mem_dm = 2'h0;
  assign mem_dq_o = st_ff.dq;
  assign mem_dq_oe_n = st_ff.dq_oe_n;
  assign mem_dqs_o = {2{st_ff.dqs}};
  assign mem_dqs_oe_n = {2{st_ff.dqs_oe_n}};
endmodule
`default_nettype wire

/* ddr_timing_ctrl_props.sv */
// assertions on the pins of the ddr command timing controller
`timescale 1ns/1ps
`default_nettype none
`include "ddr_ctrl_consts.svh"
module ddr_timing_ctrl_props
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mem_ck,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [1:0] mem_dqs_o,
  input wire logic [1:0] mem_dqs_oe_n
);
  logic ck_q;
  logic ckr;
  logic [3:0] pins;
  assign pins = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  assign ckr = mem_ck & ~ck_q;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      ck_q <= 1'b0;
    else
      ck_q <= mem_ck;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------
  // pin timing checks
  // --------------------------------------------------------------
  ck_duty_a: assert property (
    $rose(mem_ck) |=> mem_ck ##1 !mem_ck [*2] ##1 mem_ck)
    else $error("memory clock duty wrong");
  cmd_align_a: assert property (
    $changed(pins) |-> ##2 ckr)
    else $error("command not centred on clock rise");
  mode_gap_a: assert property (
    ckr && pins == `PIN_MRS |-> ##4 pins == `PIN_NOP)
    else $error("command too soon after mode load");
  ref_gap_a: assert property (
    ckr && pins == `PIN_REF |-> ##4 pins == `PIN_NOP ##4 pins == `PIN_NOP
      ##4 pins == `PIN_NOP)
    else $error("command too soon after refresh");
  wr_rd_gap_a: assert property (
    ckr && pins == `PIN_WRITE |-> ##4 pins != `PIN_READ
      ##4 pins != `PIN_READ ##4 pins != `PIN_READ ##4 pins != `PIN_READ)
    else $error("read too soon after write");
  pd_exit_a: assert property (
    $rose(mem_cke) |-> (pins == `PIN_NOP) [*8])
    else $error("command too soon after cke rise");
  cke_hold_a: assert property (
    $changed(mem_cke) |=> $stable(mem_cke) [*7])
    else $error("cke level too short");
  preamble_a: assert property (
    $fell(mem_dqs_oe_n[0]) |-> ckr && !mem_dqs_o[0] ##1
      (!mem_dqs_o[0] && !mem_dqs_oe_n[0]) [*3] ##1 mem_dqs_o[0])
    else $error("write strobe preamble wrong");
  strobe_high_a: assert property (
    $rose(mem_dqs_o[0]) |=> mem_dqs_o[0] ##1 !mem_dqs_o[0])
    else $error("write strobe high width wrong");
  strobe_low_a: assert property (
    $fell(mem_dqs_o[0]) |=> !mem_dqs_o[0] && !mem_dqs_oe_n[0] ##1
      (mem_dqs_o[0] || mem_dqs_oe_n[0]))
    else $error("write strobe low width wrong");
  strobe_fall_a: assert property (
    $fell(mem_dqs_o[0]) |-> $fell(mem_ck))
    else $error("strobe fall off clock centre");
  first_rise_a: assert property (
    ckr && pins == `PIN_WRITE |-> ##4 $rose(mem_dqs_o[0]))
    else $error("first strobe rise misplaced");
endmodule
bind ddr_timing_ctrl ddr_timing_ctrl_props props_i (.core_clk, .rst_n,
  .mem_ck, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n,
  .mem_dqs_o, .mem_dqs_oe_n);
`default_nettype wire

/* lpddr_model.sv */
// behavioural sdram die: stores write bursts, answers read bursts
`timescale 1ns/1ps
`default_nettype none
`include "ddr_ctrl_consts.svh"
module lpddr_model
(
  input wire logic core_clk,
  input wire logic mem_ck,
  input wire logic [3:0] pins,
  input wire logic [1:0] mem_ba,
  input wire logic [13:0] mem_a,
  input wire logic [15:0] mem_dq_o,
  input wire logic mem_dq_oe_n,
  input wire logic mem_dqs_o,
  output logic [15:0] mem_dq_i,
  output logic [1:0] mem_dqs_i
);
  logic [15:0] store [int];
  int wbase;
  int wbeat;
  // ----------------------------------------------------------------
  // read burst, cas latency 3, released data lines show inverse
  // ----------------------------------------------------------------
  task automatic send(input int base);
    repeat (12) @(posedge core_clk);
    for (int k = 0; k < 4; k++)
    begin
      mem_dq_i <= store[base + k];
      mem_dqs_i <= {2{~mem_dqs_i[0]}};
      repeat (2) @(posedge core_clk);
    end
    mem_dq_i <= ~mem_dq_i;
  endtask
  initial
  begin
    mem_dq_i = 16'h0000;
    mem_dqs_i = 2'b00;
    wbeat = 4;
  end
  always @(mem_dqs_o)
    if (wbeat < 4 && mem_dq_oe_n === 1'b0)
    begin
      store[wbase + wbeat] = mem_dq_o;
      wbeat++;
    end
  always @(posedge mem_ck)
    if (pins == `PIN_WRITE)
    begin
      wbase = {mem_ba, mem_a[9:0]};
      wbeat = 0;
    end
    else if (pins == `PIN_READ)
      send({mem_ba, mem_a[9:0]});
endmodule
`default_nettype wire

/* tb_ddr_timing_ctrl.sv */
// self-checking bench for the ddr command timing controller
`timescale 1ns/1ps
`default_nettype none
`include "ddr_ctrl_consts.svh"
module tb_ddr_timing_ctrl;
  import ddr_ctrl_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_e cmd_op = OP_NOP;
  logic [1:0] cmd_bank = 2'b00;
  logic [13:0] cmd_addr = 14'h0000;
  logic wr_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic cmd_ready, wr_ready, rd_valid, mem_ck, mem_ck_n, mem_cke, ck_q;
  logic mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_dq_oe_n;
  logic [1:0] mem_ba, mem_dm, mem_dqs_o, mem_dqs_oe_n, mem_dqs_i;
  logic [13:0] mem_a;
  logic [15:0] rd_data, mem_dq_o, mem_dq_i;
  logic [3:0] pins;
  int cyc = 0;
  int refs = 0;
  int err_total = 0;
  int num_checks = 0;
  int t0, t1, t2;
  assign pins = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  ddr_timing_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .mem_ck(mem_ck), .mem_ck_n(mem_ck_n),
    .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba),
    .mem_a(mem_a), .mem_dm(mem_dm), .mem_dq_o(mem_dq_o),
    .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_i(mem_dq_i), .mem_dqs_o(mem_dqs_o),
    .mem_dqs_oe_n(mem_dqs_oe_n), .mem_dqs_i(mem_dqs_i));
  lpddr_model mem (.core_clk(core_clk), .mem_ck(mem_ck), .pins(pins),
    .mem_ba(mem_ba), .mem_a(mem_a), .mem_dq_o(mem_dq_o),
    .mem_dq_oe_n(mem_dq_oe_n), .mem_dqs_o(mem_dqs_o[0]),
    .mem_dq_i(mem_dq_i), .mem_dqs_i(mem_dqs_i));
  initial
    forever #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    ck_q <= mem_ck;
    if (mem_ck && !ck_q && pins == `PIN_REF)
      refs <= refs + 1;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic issue(input cmd_e op, input logic [13:0] a, output int t);
    int n;
    n = 0;
    wt(1);
    cmd_op = op;
    cmd_addr = a;
    cmd_valid = 1'b1;
    #1;
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      #2;
      n++;
    end
    wt(1);
    t = cyc;
    cmd_valid = 1'b0;
    chk(n < 3000, "command never taken");
  endtask
  task automatic rd_chk(input logic [15:0] w);
    int k, n;
    k = 0;
    n = 0;
    while (k < 4 && n < 60)
    begin
      wt(1);
      n++;
      if (rd_valid === 1'b1)
      begin
        chk(rd_data === w, "read data");
        w = w + 16'h0111;
        k++;
      end
    end
    chk(k == 4, "read beat count");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wt(3);
    chk(pins === `PIN_NOP && mem_cke === 1'b0, "reset pins");
    chk(mem_dqs_oe_n === 2'b11 && rd_valid === 1'b0, "reset dqs");
    chk(mem_dm === 2'b00 && mem_ck_n === 1'b1, "reset clock pins");
    rst_n = 1'b1;
    $display("done reset");
  endtask
  task automatic t_power();
    issue(OP_PD_EXIT, 14'h0000, t0);
    wt(4);
    chk(mem_cke === 1'b1, "cke low after exit");
    issue(OP_MODE_LOAD, 14'h0032, t1);
    issue(OP_MODE_LOAD, 14'h0000, t2);
    chk(t2 - t1 >= 8, "mode load gap");
    issue(OP_PD_ENTER, 14'h0000, t0);
    wt(4);
    chk(mem_cke === 1'b0, "cke high in power-down");
    issue(OP_PD_EXIT, 14'h0000, t1);
    issue(OP_MODE_LOAD, 14'h0032, t2);
    chk(t1 - t0 >= 8 && t2 - t1 >= 8, "power-down gaps");
    $display("done power and mode");
  endtask
  task automatic t_refresh();
    int n;
    n = refs;
    t0 = 0;
    while (refs == n && t0 < 1600)
    begin
      wt(1);
      t0++;
    end
    chk(refs > n, "no refresh in interval");
    $display("done refresh");
  endtask
  task automatic t_burst();
    int n;
    n = 0;
    wr_valid = 1'b1;
    wr_data = 16'ha000;
    repeat (10)
    begin
      #1;
      if (wr_ready === 1'b1)
      begin
        wt(1);
        n++;
        wr_data = wr_data + 16'h0111;
      end
      else
        wt(1);
    end
    wr_valid = 1'b0;
    chk(n == 8 && wr_ready === 1'b0, "buffer depth");
    issue(OP_ACTIVATE, 14'h0000, t0);
    issue(OP_WRITE, 14'h0008, t1);
    issue(OP_WRITE, 14'h0010, t1);
    issue(OP_READ, 14'h0008, t2);
    chk(t2 - t1 >= 20, "write to read gap");
    rd_chk(16'ha000);
    issue(OP_READ, 14'h0010, t2);
    rd_chk(16'ha444);
    issue(OP_PRECHARGE, 14'h0400, t0);
    $display("done write and read");
  endtask
  task automatic t_self();
    issue(OP_SR_ENTER, 14'h0000, t0);
    wt(8);
    chk(mem_cke === 1'b0, "cke high in self refresh");
    issue(OP_SR_EXIT, 14'h0000, t1);
    issue(OP_ACTIVATE, 14'h0000, t2);
    chk(t2 - t1 >= 12, "self refresh exit gap");
    cmd_bank = 2'b01;
    issue(OP_ACTIVATE, 14'h0000, t1);
    chk(t1 - t2 >= 4, "activate to activate gap");
    issue(OP_PRECHARGE, 14'h0000, t0);
    $display("done self refresh");
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end
  initial
  begin
    t_reset();
    t_power();
    t_refresh();
    t_burst();
    t_self();
    end_sim();
  end
endmodule
`default_nettype wire
